// ---- bench/mac_link_model.sv ----
// Behavioural MAC on the link pins: free link clock, nibble or two-bit framing
`timescale 1ns/100ps
module mac_link_model (
    // Link pins
    output logic                       o_link_clk,
    output phy_port_pkg::mac_tx_s      o_mac_tx,
    input  wire phy_port_pkg::mac_rx_s i_mac_rx,
    // High selects two-bit units
    input  wire logic                  i_two_bit,
    // Bytes taken off the receive pins
    output logic [7:0]                 o_rx_byte,
    output logic                       o_rx_strobe
);
    logic [7:0] acc;
    int         k;
    // Link clock runs free at 80 ns, as a MAC-side reference clock does
    initial begin
        o_link_clk = 1'b0;
        o_mac_tx = '0;
        o_rx_byte = 8'h00;
        o_rx_strobe = 1'b0;
        acc = 8'h00;
        k = 0;
        forever #40 o_link_clk = ~o_link_clk;
    end
    // Receive: low unit first, counted only while the valid line is up
    always @(posedge o_link_clk) begin
        if (i_two_bit ? i_mac_rx.crs_dv : i_mac_rx.rx_dv) begin
            acc = i_two_bit ? {i_mac_rx.rxd[1:0], acc[7:2]} : {i_mac_rx.rxd, acc[7:4]};
            k = k + 1;
            o_rx_strobe <= (k == (i_two_bit ? 4 : 2));
            if (k == (i_two_bit ? 4 : 2)) begin
                o_rx_byte <= acc;
                k = 0;
            end
        end else begin
            o_rx_strobe <= 1'b0;
            k = 0;
        end
    end
    // Idle data lines keep changing so that stale bits are never mistaken for data
    always @(posedge o_link_clk) begin
        if (!o_mac_tx.en) o_mac_tx.txd <= ~o_mac_tx.txd;
    end
    // Units change on the falling edge, stable at the device's rising sample
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < (i_two_bit ? 4 : 2); i++) begin
            @(negedge o_link_clk);
            o_mac_tx.en <= 1'b1;
            o_mac_tx.txd <= i_two_bit ? {2'h0, b[2*i +: 2]} : b[4*i +: 4];
        end
    endtask
    task automatic stop();
        @(negedge o_link_clk);
        o_mac_tx.en <= 1'b0;
    endtask
endmodule // mac_link_model

// ---- bench/phy_mac_port_led_strap_checker.sv ----
// Concurrent checks on the ports of the MAC port, indicator and strap block
`timescale 1ns/100ps
module phy_mac_port_led_strap_checker #(
    parameter int unsigned BLINK_CYCLES = 4
) (
    // Clock, reset and register writes
    input wire logic                  i_clk_sys,
    input wire logic                  i_nrst,
    input wire logic [4:0]            i_addr,
    input wire logic [15:0]           i_wdata,
    input wire logic                  i_wr,
    // Pins and status
    input wire logic                  i_activity,
    input wire logic                  o_second_indicator_out,
    input wire logic                  o_second_indicator_oe,
    input wire logic                  o_speed_100,
    input wire logic                  o_fiber_mode,
    input wire logic                  o_fiber_signal_detect,
    input wire logic                  o_tx_valid,
    input wire phy_port_pkg::mac_rx_s o_mac_rx
);
    localparam int unsigned HOLD_MAX = 2 * BLINK_CYCLES + 2;
    logic [1:0]  mode_reg;
    logic [1:0]  mode_next;
    logic [15:0] hold_reg;
    logic [15:0] hold_next;
    logic        out_reg;
    // =====
    // Shadow of the mode field; oe stands in for "running" since early writes drop
    always_comb begin
        mode_next = mode_reg;
        hold_next = 16'h0000;
        if (i_wr && o_second_indicator_oe && i_addr == phy_port_pkg::REG_INDICATOR_CTRL) begin
            mode_next = i_wdata[15:14];
        end
        if (mode_reg == phy_port_pkg::IND_ACTIVITY && i_activity
                && o_second_indicator_out == out_reg) begin
            hold_next = hold_reg + 16'h0001;
        end
    end
    // Registers of the shadow
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_reg <= 2'h0;
            hold_reg <= 16'h0000;
            out_reg  <= 1'b1;
        end else begin
            mode_reg <= mode_next;
            hold_reg <= hold_next;
            out_reg  <= o_second_indicator_out;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    property p_reset_state;
        $rose(i_nrst) |-> !o_second_indicator_oe && o_second_indicator_out && o_speed_100
            && !o_fiber_mode && !o_tx_valid;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state at reset release");
    property p_strap_window;
        $rose(i_nrst) |-> !o_second_indicator_oe ##[2:4] o_second_indicator_oe;
    endproperty
    a_strap_window: assert property (p_strap_window) else $error("pin drive window wrong");
    property p_led_speed;
        mode_reg == 2'h0 && $past(mode_reg) == 2'h0 && $past(o_second_indicator_oe)
            && $stable(o_speed_100) |-> o_second_indicator_out == !o_speed_100;
    endproperty
    a_led_speed: assert property (p_led_speed) else $error("speed indicator wrong");
    property p_led_reserved;
        mode_reg[1] && $past(mode_reg[1]) && $past(o_second_indicator_oe) |-> o_second_indicator_out;
    endproperty
    a_led_reserved: assert property (p_led_reserved) else $error("reserved mode not off");
    property p_led_idle;
        mode_reg == 2'h1 && $past(mode_reg) == 2'h1 && !$past(i_activity) && !$past(i_activity, 2)
            && $past(o_second_indicator_oe) |-> o_second_indicator_out;
    endproperty
    a_led_idle: assert property (p_led_idle) else $error("idle activity indicator not off");
    property p_led_blink;
        hold_reg <= HOLD_MAX;
    endproperty
    a_led_blink: assert property (p_led_blink) else $error("activity indicator stuck");
    property p_fiber_speed;
        o_fiber_mode |-> o_speed_100;
    endproperty
    a_fiber_speed: assert property (p_fiber_speed) else $error("fiber not at 100");
    property p_detect;
        o_fiber_signal_detect |-> o_fiber_mode;
    endproperty
    a_detect: assert property (p_detect) else $error("signal detect outside fiber");
    property p_rx_idle;
        !o_mac_rx.rx_dv && !o_mac_rx.crs_dv |-> o_mac_rx.rxd == 4'h0;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("receive data without valid");
    c_blink: cover property (mode_reg == 2'h1 && $changed(o_second_indicator_out));
    c_tx: cover property (o_tx_valid);
    c_fiber: cover property (o_fiber_mode && o_fiber_signal_detect);
endmodule // phy_mac_port_led_strap_checker
bind phy_mac_port_led_strap phy_mac_port_led_strap_checker #(.BLINK_CYCLES(BLINK_CYCLES))
    u_phy_mac_port_led_strap_checker (.*);

// ---- bench/phy_mac_port_led_strap_test.sv ----
// Self-checking bench: straps, indicator modes, registers and byte traffic
`timescale 1ns/100ps
module phy_mac_port_led_strap_test;
    logic i_clk_sys, i_nrst, i_wr, i_rd, i_link_clk, i_rx_valid, o_rx_ready, o_tx_valid;
    logic o_tx_err, i_fiber_pin, i_led_in, o_second_indicator_out, o_second_indicator_oe;
    logic i_activity, o_fiber_mode, o_speed_100, o_far_end_fault_off, o_fiber_signal_detect;
    logic [4:0] i_addr;
    logic [15:0] i_wdata, o_rdata;
    logic [7:0] i_rx_data, o_tx_data, rx_byte;
    logic [2:0] i_mode_strap;
    logic rx_strobe, led_strap, prev;
    phy_port_pkg::mac_tx_s i_mac_tx;
    phy_port_pkg::mac_rx_s o_mac_rx;
    int failures, n_tests, cycles;
    logic [31:0] seed;
    logic [7:0] exp_q[$], rx_q[$], tx_q[$];
    // Pin level: the led_strap level while released, the device's own drive otherwise
    assign i_led_in = o_second_indicator_oe ? o_second_indicator_out : led_strap;
    phy_mac_port_led_strap #(.BLINK_CYCLES(4)) u_phy_mac_port_led_strap (.*);
    mac_link_model u_mac_link_model (.o_link_clk(i_link_clk), .o_mac_tx(i_mac_tx),
        .i_mac_rx(o_mac_rx), .i_two_bit(i_mode_strap[0]), .o_rx_byte(rx_byte),
        .o_rx_strobe(rx_strobe));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] want);
        @(posedge i_clk_sys);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 check(o_rdata, want);
    endtask
    // Reset with fresh straps; the first bus access waits past the latch edge
    task automatic boot(input logic [2:0] m, input logic fib, input logic led);
        @(posedge i_clk_sys);
        i_nrst <= 1'b0; i_mode_strap <= m; i_fiber_pin <= fib; led_strap <= led;
        repeat (2) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
    endtask
    task automatic led_mode(input logic [1:0] m, input logic want);
        wr(5'h1E, {m, 14'h0000});
        repeat (4) @(posedge i_clk_sys);
        #1 check(16'(o_second_indicator_out), 16'(want));
        rd(5'h1E, {m, 14'h0000});
    endtask
    task automatic compare_q(ref logic [7:0] got[$]);
        check(16'(got.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) check({8'h00, got[i]}, {8'h00, exp_q[i]});
    endtask
    // Back-to-back random bytes each way; the bench's exp_q of sent bytes is the expectation
    task automatic traffic(input int n);
        exp_q = {}; rx_q = {}; tx_q = {};
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            exp_q.push_back(seed[7:0]);
            i_rx_data <= seed[7:0]; i_rx_valid <= 1'b1;
            do @(negedge i_clk_sys); while (o_rx_ready !== 1'b1);
            @(posedge i_clk_sys);
        end
        i_rx_valid <= 1'b0;
        repeat (40) @(posedge i_clk_sys);
        compare_q(rx_q);
        foreach (exp_q[i]) u_mac_link_model.send_byte(exp_q[i]);
        u_mac_link_model.stop();
        repeat (40) @(posedge i_clk_sys);
        compare_q(tx_q);
    endtask
    always @(posedge rx_strobe) rx_q.push_back(rx_byte);
    // Capture of device bytes, and the watchdog against a hang
    always @(posedge i_clk_sys) begin
        if (o_tx_valid === 1'b1) tx_q.push_back(o_tx_data);
        cycles++;
        if (cycles > 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_nrst = 1'b0; i_addr = 5'h00; i_wdata = 16'h0000; i_wr = 1'b0; i_rd = 1'b0;
        i_rx_data = 8'h00; i_rx_valid = 1'b0; i_mode_strap = 3'h0; i_fiber_pin = 1'b0;
        i_activity = 1'b0; led_strap = 1'b1; failures = 0; n_tests = 0; cycles = 0;
        seed = 32'h5AD0;
        boot(3'h0, 1'b0, 1'b1);
        rd(5'h1B, 16'h0040);
        rd(5'h00, 16'h2000);
        rd(5'h05, 16'h0000);
        led_mode(2'h0, 1'b0);
        led_mode(2'h2, 1'b1);
        led_mode(2'h3, 1'b1);
        led_mode(2'h1, 1'b1);
        i_activity <= 1'b1;
        prev = o_second_indicator_out;
        for (int i = 0, t = 0; i < 30; i++) begin
            @(posedge i_clk_sys);
            #1 t += (o_second_indicator_out != prev);
            prev = o_second_indicator_out;
            if (i == 29) check(16'(t >= 6 && t <= 8), 16'h0001);
        end
        i_activity <= 1'b0;
        wr(5'h00, 16'h0000);
        led_mode(2'h0, 1'b1);
        rd(5'h00, 16'h0000);
        traffic(6);
        boot(3'h1, 1'b0, 1'b0);
        rd(5'h00, 16'h0000);
        rd(5'h1B, 16'h0041);
        traffic(6);
        boot(3'h2, 1'b0, 1'b1);
        rd(5'h1B, 16'h0042);
        boot(3'h0, 1'b1, 1'b1);
        rd(5'h1B, 16'h0078);
        rd(5'h00, 16'h2000);
        check({o_fiber_mode, o_far_end_fault_off, o_fiber_signal_detect}, 16'h0007);
        i_fiber_pin <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        #1 check({15'h0000, o_fiber_signal_detect}, 16'h0000);
        stop_test();
    end
endmodule // phy_mac_port_led_strap_test

// ---- design/phy_mac_port_led_strap.sv ----
// MAC data port in MII, RMII and SMII framing with indicator pin and reset straps
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
module phy_mac_port_led_strap #(
    parameter int unsigned BLINK_CYCLES = phy_port_pkg::BLINK_CYCLES
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    // Register port
    input  wire logic [4:0]            i_addr,
    input  wire logic [15:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [15:0]           o_rdata,
    // MAC link pins
    input  wire logic                  i_link_clk,
    input  wire phy_port_pkg::mac_tx_s i_mac_tx,
    output phy_port_pkg::mac_rx_s      o_mac_rx,
    // Core receive stream
    input  wire logic [7:0]            i_rx_data,
    input  wire logic                  i_rx_valid,
    output logic                       o_rx_ready,
    // Core transmit stream
    output logic      [7:0]            o_tx_data,
    output logic                       o_tx_valid,
    output logic                       o_tx_err,
    // Strap and indicator pins
    input  wire logic [2:0]            i_mode_strap,
    input  wire logic                  i_fiber_pin,
    input  wire logic                  i_led_in,
    output logic                       o_second_indicator_out,
    output logic                       o_second_indicator_oe,
    input  wire logic                  i_activity,
    // Latched configuration, speed writable by register, and live fiber signal detect
    output logic                       o_fiber_mode,
    output logic                       o_speed_100,
    output logic                       o_far_end_fault_off,
    output logic                       o_fiber_signal_detect
);
    // =========================================================
    // Helpers
    // Link clock edges per byte for each framing
    function automatic logic [3:0] units_per_byte(input logic [2:0] m);
        if (m == phy_port_pkg::MODE_RMII) begin
            return phy_port_pkg::RMII_UNITS;
        end else if (m == phy_port_pkg::MODE_SMII) begin
            return phy_port_pkg::SEG_BITS;
        end
        return phy_port_pkg::MII_UNITS;
    endfunction
    // =========================================================
    // Pin synchronisers
    logic                  lclk_s1, lclk_s2, lclk_prev;
    phy_port_pkg::mac_tx_s tx_s1, tx_s2;
    logic [2:0]            mode_s1, mode_s2;
    logic                  fib_s1, fib_s2;
    logic                  led_s1, led_s2;
    logic                  edge_hit;
    // Every pin but i_activity crosses two flops; the link clock is only sampled, never used as a clock
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            {lclk_s1, lclk_s2, lclk_prev, fib_s1, fib_s2, led_s1, led_s2} <= 7'h00;
            {mode_s1, mode_s2, tx_s1, tx_s2} <= 20'h00000;
        end else begin
            {lclk_s1, fib_s1, led_s1, mode_s1, tx_s1} <=
                {i_link_clk, i_fiber_pin, i_led_in, i_mode_strap, i_mac_tx};
            {lclk_s2, fib_s2, led_s2, mode_s2, tx_s2} <=
                {lclk_s1, fib_s1, led_s1, mode_s1, tx_s1};
            lclk_prev <= lclk_s2;
        end
    end
    // Rising edge of the sampled link clock
    assign edge_hit = lclk_s2 & ~lclk_prev;
    // =========================================================
    // Strap latch and registers
    phy_port_pkg::strap_state_e st_reg, st_next;
    logic [1:0]  cnt_reg, cnt_next;
    logic [2:0]  mode_reg, mode_next;
    logic        fiber_reg, fiber_next;
    logic        fef_reg, fef_next;
    logic        speed_reg, speed_next;
    logic [1:0]  ind_reg, ind_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        run, spd100;
    assign run    = (st_reg == phy_port_pkg::ST_RUN);
    assign spd100 = fiber_reg | speed_reg; // Fiber runs at 100 Mb/s only
    // Settle the synchronisers after release, latch straps once, then serve the bus
    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        mode_next  = mode_reg;
        fiber_next = fiber_reg;
        fef_next   = fef_reg;
        speed_next = speed_reg;
        ind_next   = ind_reg;
        rdata_next = 16'h0000;
        case (st_reg)
            phy_port_pkg::ST_SETTLE: begin
                if (cnt_reg == phy_port_pkg::SETTLE_CYCLES - 2'h1) begin
                    st_next = phy_port_pkg::ST_LATCH;
                end else begin
                    cnt_next = cnt_reg + 2'h1;
                end
            end
            phy_port_pkg::ST_LATCH: begin
                mode_next  = mode_s2;
                fiber_next = fib_s2;
                if (fib_s2) begin
                    fef_next = led_s2;
                end else begin
                    speed_next = led_s2;
                end
                st_next = phy_port_pkg::ST_RUN;
            end
            phy_port_pkg::ST_RUN: begin
                if (i_wr) begin
                    if (i_addr == phy_port_pkg::REG_CONTROL) begin
                        speed_next = i_wdata[phy_port_pkg::SPEED_BIT];
                    end else if (i_addr == phy_port_pkg::REG_INDICATOR_CTRL) begin
                        ind_next = i_wdata[phy_port_pkg::IND_MODE_LSB +: 2];
                    end
                end
            end
            default: begin
                st_next = phy_port_pkg::ST_SETTLE;
            end
        endcase
        // Read data is presented only in the cycle after the strobe
        if (i_rd) begin
            if (i_addr == phy_port_pkg::REG_CONTROL) begin
                rdata_next[phy_port_pkg::SPEED_BIT] = spd100;
            end else if (i_addr == phy_port_pkg::REG_INDICATOR_CTRL) begin
                rdata_next[phy_port_pkg::IND_MODE_LSB +: 2] = ind_reg;
            end else if (i_addr == phy_port_pkg::REG_PORT_STATUS) begin
                rdata_next[2:0] = mode_reg;
                rdata_next[3]   = fiber_reg;
                rdata_next[4]   = fef_reg;
                rdata_next[5]   = fiber_reg & fib_s2;
                rdata_next[6]   = run;
            end
        end
    end
    // Registers of the strap and bus group
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= phy_port_pkg::ST_SETTLE;
            {cnt_reg, mode_reg, fiber_reg, fef_reg, speed_reg, ind_reg, rdata_reg} <=
                {2'h0, phy_port_pkg::MODE_MII, 2'h0, phy_port_pkg::SPEED_RST,
                 phy_port_pkg::IND_MODE_RST, 16'h0000};
        end else begin
            st_reg <= st_next;
            {cnt_reg, mode_reg, fiber_reg, fef_reg, speed_reg, ind_reg, rdata_reg} <=
                {cnt_next, mode_next, fiber_next, fef_next, speed_next, ind_next, rdata_next};
        end
    end
    // =========================================================
    // Indicator pin
    logic [31:0] blink_reg, blink_next;
    logic        tog_reg, tog_next;
    logic        led_reg, led_next;
    // Blink only while activity lasts; idle returns the pin to high (off)
    always_comb begin
        blink_next = 32'h0;
        tog_next   = 1'h1;
        if (i_activity) begin
            tog_next = tog_reg;
            if (blink_reg == BLINK_CYCLES - 1) begin
                tog_next = ~tog_reg;
            end else begin
                blink_next = blink_reg + 32'h1;
            end
        end
        case (ind_reg)
            phy_port_pkg::IND_SPEED:    led_next = ~spd100;
            phy_port_pkg::IND_ACTIVITY: led_next = tog_reg;
            default:                    led_next = 1'h1;
        endcase
    end
    // Registers of the indicator group; the pin idles high (off)
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            {blink_reg, tog_reg, led_reg} <= 34'h000000003;
        end else begin
            {blink_reg, tog_reg, led_reg} <= {blink_next, tog_next, led_next};
        end
    end
    // =========================================================
    // Receive framing toward the MAC
    logic [3:0]            rph_reg, rph_next;
    logic [3:0]            rrep_reg, rrep_next;
    logic [7:0]            rbyte_reg, rbyte_next;
    logic                  rdv_reg, rdv_next;
    phy_port_pkg::mac_rx_s pins_reg, pins_next;
    logic                  take;
    // A byte is taken at the first unit of each byte slot on a link edge
    always_comb begin
        logic [3:0] last, p;
        logic [7:0] sh;
        logic [9:0] seg;
        last       = 4'h0;
        p          = 4'h0;
        sh         = 8'h00;
        seg        = 10'h000;
        rph_next   = rph_reg;
        rrep_next  = rrep_reg;
        rbyte_next = rbyte_reg;
        rdv_next   = rdv_reg;
        pins_next  = pins_reg;
        take       = 1'h0;
        if (run && edge_hit) begin
            last = units_per_byte(mode_reg) - 4'h1;
            p    = rph_reg;
            if (mode_reg == phy_port_pkg::MODE_SMII && tx_s2.sync) begin
                p = 4'h0;                                 // Segment start set by MAC sync
            end
            rph_next = (p == last) ? 4'h0 : p + 4'h1;
            if (p == 4'h0) begin
                if (mode_reg == phy_port_pkg::MODE_SMII) begin
                    rrep_next = (spd100 || rrep_reg == phy_port_pkg::SMII_REPEAT - 4'h1)
                              ? 4'h0 : rrep_reg + 4'h1;
                end
                if (mode_reg == phy_port_pkg::MODE_SMII && !spd100 && rrep_reg != 4'h0) begin
                    rbyte_next = rbyte_reg;
                end else if (i_rx_valid) begin
                    take       = 1'h1;
                    rbyte_next = i_rx_data;
                    rdv_next   = 1'h1;
                end else begin
                    rdv_next   = 1'h0;
                end
            end
            sh  = rbyte_next >> {p[2:0], 1'b0};
            seg = {rdv_next ? rbyte_next : 8'h00, rdv_next, rdv_next}; // Idle data bits low
            pins_next.crs_dv = rdv_next;
            pins_next.rx_dv  = rdv_next;
            if (mode_reg == phy_port_pkg::MODE_RMII) begin
                pins_next.rxd = rdv_next ? {2'b00, sh[1:0]} : 4'h0;
            end else if (mode_reg == phy_port_pkg::MODE_SMII) begin
                pins_next.rxd = {3'b000, seg[p]};
            end else begin
                pins_next.rxd = !rdv_next ? 4'h0
                              : (p == 4'h0) ? rbyte_next[3:0] : rbyte_next[7:4];
            end
        end else if (!run) begin
            pins_next = '0;
        end
    end
    // Registers of the receive group
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            {rph_reg, rrep_reg, rbyte_reg, rdv_reg, pins_reg} <= 23'h000000;
        end else begin
            {rph_reg, rrep_reg, rbyte_reg, rdv_reg, pins_reg} <=
                {rph_next, rrep_next, rbyte_next, rdv_next, pins_next};
        end
    end
    // =========================================================
    // Transmit framing from the MAC
    logic [3:0] tph_reg, tph_next;
    logic [3:0] trep_reg, trep_next;
    logic [9:0] acc_reg, acc_next;
    logic [7:0] tdata_reg, tdata_next;
    logic       tval_reg, tval_next;
    logic       terr_reg, terr_next;
    // Bits shift in LSB first so the byte always lands in acc[9:2]
    always_comb begin
        logic [3:0] last, p;
        last       = 4'h0;
        p          = 4'h0;
        tph_next   = tph_reg;
        trep_next  = trep_reg;
        acc_next   = acc_reg;
        tdata_next = tdata_reg;
        tval_next  = 1'h0;
        terr_next  = terr_reg;
        if (run && edge_hit) begin
            last = units_per_byte(mode_reg) - 4'h1;
            if (mode_reg == phy_port_pkg::MODE_SMII) begin
                p        = tx_s2.sync ? 4'h0 : tph_reg;
                acc_next = {tx_s2.txd[0], acc_reg[9:1]};
                tph_next = (p == last) ? 4'h0 : p + 4'h1;
                if (p == last) begin
                    trep_next = (spd100 || trep_reg == phy_port_pkg::SMII_REPEAT - 4'h1)
                              ? 4'h0 : trep_reg + 4'h1;
                    if (acc_next[1] && (spd100 || trep_reg == 4'h0)) begin
                        tval_next  = 1'h1;
                        tdata_next = acc_next[9:2];
                        terr_next  = acc_next[0];
                    end
                end
            end else if (!tx_s2.en) begin
                tph_next = 4'h0;
            end else begin
                if (mode_reg == phy_port_pkg::MODE_RMII) begin
                    acc_next = {tx_s2.txd[1:0], acc_reg[9:2]};
                end else begin
                    acc_next = {tx_s2.txd, acc_reg[9:4]};
                end
                tph_next = (tph_reg == last) ? 4'h0 : tph_reg + 4'h1;
                if (tph_reg == last) begin
                    tval_next  = 1'h1;
                    tdata_next = acc_next[9:2];
                    terr_next  = tx_s2.er;
                end
            end
        end
    end
    // Registers of the transmit group
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            {tph_reg, trep_reg, acc_reg, tdata_reg, tval_reg, terr_reg} <= 28'h0000000;
        end else begin
            {tph_reg, trep_reg, acc_reg, tdata_reg, tval_reg, terr_reg} <=
                {tph_next, trep_next, acc_next, tdata_next, tval_next, terr_next};
        end
    end
    // =========================================================
    // Outputs
    // Pin stays released until straps are latched so the pull sets its level
    assign o_second_indicator_oe  = run;
    assign o_second_indicator_out = led_reg;
    assign o_rdata                = rdata_reg;
    assign o_mac_rx               = pins_reg;
    assign o_rx_ready             = take;
    assign o_tx_data              = tdata_reg;
    assign o_tx_valid             = tval_reg;
    assign o_tx_err               = terr_reg;
    assign o_fiber_mode           = fiber_reg;
    assign o_speed_100            = spd100;
    assign o_far_end_fault_off    = fef_reg;
    assign o_fiber_signal_detect  = fiber_reg & fib_s2;
endmodule // phy_mac_port_led_strap

// ---- design/phy_port_pkg.sv ----
// Package with constants, types and pin groups for the MAC port, indicator and strap block
package phy_port_pkg;
    // =========================================================
    // Register map
    localparam logic [4:0]  REG_CONTROL        = 5'h00;
    localparam logic [4:0]  REG_PORT_STATUS    = 5'h1B;
    localparam logic [4:0]  REG_INDICATOR_CTRL = 5'h1E;
    localparam int          SPEED_BIT          = 13;
    localparam int          IND_MODE_LSB       = 14;
    localparam logic        SPEED_RST          = 1'h1;
    localparam logic [1:0]  IND_MODE_RST       = 2'h0;
    localparam logic [1:0]  IND_SPEED          = 2'h0;
    localparam logic [1:0]  IND_ACTIVITY       = 2'h1;
    // =========================================================
    // Interface modes and framing
    localparam logic [2:0]  MODE_MII           = 3'h0;
    localparam logic [2:0]  MODE_RMII          = 3'h1;
    localparam logic [2:0]  MODE_SMII          = 3'h2;
    localparam logic [3:0]  MII_UNITS          = 4'h2;
    localparam logic [3:0]  RMII_UNITS         = 4'h4;
    localparam logic [3:0]  SEG_BITS           = 4'hA;
    localparam logic [3:0]  SMII_REPEAT        = 4'hA;
    // =========================================================
    // Timing
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          BLINK_HALF_NS      = 50000000;
    localparam int          BLINK_CYCLES       = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  SETTLE_CYCLES      = 2'h3;
    // =========================================================
    // Types
    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_LATCH  = 3'b010,
        ST_RUN    = 3'b100
    } strap_state_e;
    typedef struct packed {
        logic       crs_dv;
        logic       rx_dv;
        logic [3:0] rxd;
    } mac_rx_s;
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] txd;
        logic       sync;
    } mac_tx_s;
endpackage
